// file: verilog/canmh_map.svh
// Notes on behaviour
// - test bits writable only while test enabled
// - receive monitor bit shows receive pin level
// - test enable low disables all test functions
// - silent: receive only, recessive out, no transmit
// - silent: dominant bits looped back internally
// - loop back: own frames received and stored
// - loop back ignores acknowledge errors
// - loop back: tx fed to rx, pin ignored
// - loop back plus silent: rx cut, tx recessive
// - basic mode never touches message memory
// - basic: set one busy sends, locks, clears
// - clearing set one busy aborts, no retry
// - basic: frames copied to set two, snapshot
// - basic: masks ignored, flags and length kept
// - basic: handler ready output stays inactive
// - select bits choose transmit pin function
// - reset clears only object flag bits
// - command request starts transfer, busy meanwhile
// - write to memory is read-modify-write
// - partial write refreshes, partial read keeps
// - init stops bus transmit but not memory transfer, transmit pin recessive
`ifndef CANMH_MAP_SVH
`define CANMH_MAP_SVH
`define CANMH_ADR_CTRL     8'h00
`define CANMH_ADR_TEST     8'h04
`define CANMH_ADR_IF_BASE  8'h20
`define CANMH_IF_STRIDE    8'h20
`define CANMH_IF_CMDREQ    3'd0
`define CANMH_IF_CMDMASK   3'd1
`define CANMH_IF_PART0     3'd2
`define CANMH_CTRL_INIT    0
`define CANMH_CTRL_TEST    7
`define CANMH_TEST_BASIC   2
`define CANMH_TEST_SILENT  3
`define CANMH_TEST_LOOPBACK_ENABLE   4
`define CANMH_TEST_SEL_LO  5
`define CANMH_TEST_SEL_HI  6
`define CANMH_TEST_RXMON   7
`define CANMH_REQ_BUSY     15
`define CANMH_MASK_DIR     7
`define CANMH_ARB_VALID    31
`define CANMH_CTL_NEWDAT   15
`define CANMH_CTL_LOST     14
`define CANMH_CTL_INTERRUPT_PENDING   13
`define CANMH_CTL_TRANSMIT_REQUEST     8
`define CANMH_CTL_BASIC_KEEP 32'h0000_c00f
`define CANMH_PARTS        5
`define CANMH_OBJS         32
`endif

// file: verilog/canmh_pkg.sv
package canmh_pkg;
  typedef enum logic [1:0] {
    CANMH_XF_IDLE  = 2'b00,
    CANMH_XF_READ  = 2'b01,
    CANMH_XF_WRITE = 2'b10
  } canmh_xfer_type;
  typedef enum logic [1:0] {
    CANMH_PIN_DATA   = 2'b00,
    CANMH_PIN_SAMPLE = 2'b01,
    CANMH_PIN_DOM    = 2'b10,
    CANMH_PIN_REC    = 2'b11
  } canmh_pin_type;
endpackage : canmh_pkg

// file: verilog/canmh_core.sv
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "canmh_map.svh"
module canmh_core (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        bus_receive_input,
  output logic             bus_transmit_output,
  input  wire logic        core_tx_bit,
  input  wire logic        core_sample_point,
  output logic             core_rx_bit,
  output logic             core_ack_err_ignore,
  output logic             core_tx_enable,
  input  wire logic        core_bus_idle,
  output logic             core_tx_load,
  output logic             core_tx_abort,
  output logic      [31:0] core_tx_arb,
  output logic      [31:0] core_tx_ctl,
  output logic      [31:0] core_tx_data_a,
  output logic      [31:0] core_tx_data_b,
  input  wire logic        core_tx_done,
  input  wire logic        core_tx_fail,
  input  wire logic        core_rx_valid,
  input  wire logic [31:0] core_shift_arb,
  input  wire logic [3:0]  core_shift_dlc,
  input  wire logic [31:0] core_shift_data_a,
  input  wire logic [31:0] core_shift_data_b,
  output logic             msg_wait_n
);

  logic                  init_reg;
  logic                  test_en_reg;
  logic                  basic_reg;
  logic                  silent_reg;
  logic                  loopback_enable_reg;
  logic [1:0]            pin_sel_reg;
  logic [31:0]           if_reg [0:1][0:`CANMH_PARTS-1];
  logic [7:0]            if_mask_reg [0:1];
  logic [4:0]            if_num_reg [0:1];
  logic [1:0]            busy_reg;
  logic [31:0]           obj_mem [0:`CANMH_OBJS-1][0:`CANMH_PARTS-1];
  logic [31:0]           valid_reg;
  logic [31:0]           newdat_reg;
  logic [31:0]           lost_reg;
  logic [31:0]           interrupt_pending_reg;
  logic [31:0]           transmit_request_reg;
  canmh_pkg::canmh_xfer_type xf_reg;
  logic                  xf_set_reg;
  logic                  tx_active_reg;
  logic                  basic;
  logic                  silent;
  logic                  loopback_enable;
  canmh_pkg::canmh_pin_type pin_sel;
  logic                  wb_req;
  logic                  wb_wr;
  logic                  if_hit;
  logic                  if_sel;
  logic [2:0]            if_word;
  logic [4:0]            xf_num;
  logic                  xf_dir;
  logic                  load_now;
  logic [31:0]           rd_next;

  // test functions are gated, not cleared, so settings survive a test off/on
  assign basic   = test_en_reg & basic_reg;
  assign silent  = test_en_reg & silent_reg;
  assign loopback_enable   = test_en_reg & loopback_enable_reg;
  assign pin_sel = test_en_reg ? canmh_pkg::canmh_pin_type'(pin_sel_reg)
                               : canmh_pkg::CANMH_PIN_DATA;

  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr   = wb_req & wb_we_i;
  assign if_hit  = (wb_adr_i >= `CANMH_ADR_IF_BASE) &&
                   (wb_adr_i < 8'(`CANMH_ADR_IF_BASE + 2 * `CANMH_IF_STRIDE));
  assign if_sel  = (wb_adr_i >= 8'(`CANMH_ADR_IF_BASE + `CANMH_IF_STRIDE));
  assign if_word = wb_adr_i[4:2];
  assign xf_num  = if_num_reg[xf_set_reg];
  assign xf_dir  = if_mask_reg[xf_set_reg][`CANMH_MASK_DIR];
  // silent never loads: the frame could not leave the pin anyway
  assign load_now = basic & busy_reg[0] & ~tx_active_reg & core_bus_idle
                    & ~init_reg & ~silent;

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_sel

  // memory part as seen by the interface, flag bits live in flops
  function automatic logic [31:0] obj_word(input logic [4:0] n, input int p,
                                           input logic [31:0] raw);
    logic [31:0] r;
    r = raw;
    if (p == 1) begin
      r[`CANMH_ARB_VALID] = valid_reg[n];
    end
    if (p == 2) begin
      r[`CANMH_CTL_NEWDAT] = newdat_reg[n];
      r[`CANMH_CTL_LOST]   = lost_reg[n];
      r[`CANMH_CTL_INTERRUPT_PENDING] = interrupt_pending_reg[n];
      r[`CANMH_CTL_TRANSMIT_REQUEST]   = transmit_request_reg[n];
    end
    return r;
  endfunction : obj_word

  // init comes up set so nothing reaches the bus before setup
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      init_reg    <= 1'b1;
      test_en_reg <= 1'b0;
    end else if (wb_wr && wb_adr_i == `CANMH_ADR_CTRL && wb_sel_i[0]) begin
      init_reg    <= wb_dat_i[`CANMH_CTRL_INIT];
      test_en_reg <= wb_dat_i[`CANMH_CTRL_TEST];
    end
  end

  // test bits keep their value while test mode is off
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      basic_reg   <= 1'b0;
      silent_reg  <= 1'b0;
      loopback_enable_reg   <= 1'b0;
      pin_sel_reg <= 2'b00;
    end else if (wb_wr && wb_adr_i == `CANMH_ADR_TEST && wb_sel_i[0]
                 && test_en_reg) begin
      basic_reg   <= wb_dat_i[`CANMH_TEST_BASIC];
      silent_reg  <= wb_dat_i[`CANMH_TEST_SILENT];
      loopback_enable_reg   <= wb_dat_i[`CANMH_TEST_LOOPBACK_ENABLE];
      pin_sel_reg <= wb_dat_i[`CANMH_TEST_SEL_HI:`CANMH_TEST_SEL_LO];
    end
  end

  // transmit pin and receive path; pin functions other than data disturb
  // the protocol, software keeps the default while frames run
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      bus_transmit_output <= 1'b1;
      core_rx_bit         <= 1'b1;
      core_ack_err_ignore <= 1'b0;
      core_tx_enable      <= 1'b0;
    end else begin
      case (pin_sel)
        canmh_pkg::CANMH_PIN_DATA:
          bus_transmit_output <= init_reg | silent | core_tx_bit;
        canmh_pkg::CANMH_PIN_SAMPLE: bus_transmit_output <= core_sample_point;
        canmh_pkg::CANMH_PIN_DOM:    bus_transmit_output <= 1'b0;
        canmh_pkg::CANMH_PIN_REC:    bus_transmit_output <= 1'b1;
        default:                     bus_transmit_output <= 1'b1;
      endcase
      if (loopback_enable) begin
        core_rx_bit <= core_tx_bit;
      end else if (silent) begin
        core_rx_bit <= bus_receive_input & core_tx_bit;
      end else begin
        core_rx_bit <= bus_receive_input;
      end
      core_ack_err_ignore <= loopback_enable;
      core_tx_enable      <= ~init_reg & ~silent;
    end
  end

  // message handler transfer sequencer, idle in basic mode
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      xf_reg     <= canmh_pkg::CANMH_XF_IDLE;
      xf_set_reg <= 1'b0;
    end else begin
      case (xf_reg)
        canmh_pkg::CANMH_XF_IDLE: begin
          if (!basic && busy_reg != 2'b00) begin
            xf_set_reg <= ~busy_reg[0];
            xf_reg     <= canmh_pkg::CANMH_XF_READ;
          end
        end
        canmh_pkg::CANMH_XF_READ: begin
          xf_reg <= xf_dir ? canmh_pkg::CANMH_XF_WRITE
                           : canmh_pkg::CANMH_XF_IDLE;
        end
        canmh_pkg::CANMH_XF_WRITE: xf_reg <= canmh_pkg::CANMH_XF_IDLE;
        default:                   xf_reg <= canmh_pkg::CANMH_XF_IDLE;
      endcase
    end
  end

  // whole object always written back, memory itself has no reset
  always_ff @(posedge clk_sys) begin
    if (xf_reg == canmh_pkg::CANMH_XF_WRITE) begin
      for (int p = 0; p < `CANMH_PARTS; p++) begin
        obj_mem[xf_num][p] <= if_reg[xf_set_reg][p];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      valid_reg  <= 32'h0000_0000;
      newdat_reg <= 32'h0000_0000;
      lost_reg   <= 32'h0000_0000;
      interrupt_pending_reg <= 32'h0000_0000;
      transmit_request_reg   <= 32'h0000_0000;
    end else if (xf_reg == canmh_pkg::CANMH_XF_WRITE) begin
      valid_reg[xf_num]  <= if_reg[xf_set_reg][1][`CANMH_ARB_VALID];
      newdat_reg[xf_num] <= if_reg[xf_set_reg][2][`CANMH_CTL_NEWDAT];
      lost_reg[xf_num]   <= if_reg[xf_set_reg][2][`CANMH_CTL_LOST];
      interrupt_pending_reg[xf_num] <= if_reg[xf_set_reg][2][`CANMH_CTL_INTERRUPT_PENDING];
      transmit_request_reg[xf_num]   <= if_reg[xf_set_reg][2][`CANMH_CTL_TRANSMIT_REQUEST];
    end
  end

  // interface sets: bus writes, transfer results, basic mode traffic
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_reg <= 2'b00;
      for (int s = 0; s < 2; s++) begin
        if_mask_reg[s] <= 8'h00;
        if_num_reg[s]  <= 5'h00;
        for (int p = 0; p < `CANMH_PARTS; p++) begin
          if_reg[s][p] <= 32'h0000_0000;
        end
      end
    end else begin
      if (xf_reg == canmh_pkg::CANMH_XF_READ) begin
        for (int p = 0; p < `CANMH_PARTS; p++) begin
          if (if_mask_reg[xf_set_reg][p] != xf_dir) begin
            // mask bit differs from direction: unselected parts
            // refresh on write, selected parts load on read
            if_reg[xf_set_reg][p] <= obj_word(xf_num, p, obj_mem[xf_num][p]);
          end
        end
        if (!xf_dir) begin
          busy_reg[xf_set_reg] <= 1'b0;
        end
      end
      if (xf_reg == canmh_pkg::CANMH_XF_WRITE) begin
        busy_reg[xf_set_reg] <= 1'b0;
      end
      if (basic && busy_reg[1]) begin
        busy_reg[1] <= 1'b0;
      end
      if (core_tx_done && tx_active_reg) begin
        busy_reg[0] <= 1'b0;
      end
      if (wb_wr && if_hit) begin
        if (if_word == `CANMH_IF_CMDREQ && wb_sel_i[1]) begin
          if (basic && !if_sel) begin
            busy_reg[0] <= wb_dat_i[`CANMH_REQ_BUSY];
          end else if (basic) begin
            if (wb_dat_i[`CANMH_REQ_BUSY]) begin
              busy_reg[1]  <= 1'b1;
              if_reg[1][1] <= core_shift_arb;
              if_reg[1][2] <= {if_reg[1][2][31:4], core_shift_dlc} &
                              `CANMH_CTL_BASIC_KEEP;
              if_reg[1][3] <= core_shift_data_a;
              if_reg[1][4] <= core_shift_data_b;
            end
          end else if (!busy_reg[if_sel]) begin
            if_num_reg[if_sel] <= wb_dat_i[4:0];
            busy_reg[if_sel]   <= 1'b1;
          end
        end else if (!busy_reg[if_sel]) begin
          // registers locked while a request is pending
          if (if_word == `CANMH_IF_CMDMASK) begin
            if (wb_sel_i[0]) begin
              if_mask_reg[if_sel] <= wb_dat_i[7:0];
            end else begin
              if_mask_reg[if_sel] <= if_mask_reg[if_sel];
            end
          end else if (if_word >= `CANMH_IF_PART0 &&
                       if_word < 3'(`CANMH_IF_PART0 + `CANMH_PARTS)) begin
            if_reg[if_sel][3'(if_word - `CANMH_IF_PART0)] <=
              merge_sel(if_reg[if_sel][3'(if_word - `CANMH_IF_PART0)],
                        wb_dat_i, wb_sel_i);
          end
        end
      end
      // hardware set placed last so a receive beats a software clear
      if (basic && core_rx_valid) begin
        if_reg[1][1] <= core_shift_arb;
        if_reg[1][2] <= {16'h0000,
                         1'b1, if_reg[1][2][`CANMH_CTL_NEWDAT],
                         10'h000, core_shift_dlc};
        if_reg[1][3] <= core_shift_data_a;
        if_reg[1][4] <= core_shift_data_b;
      end
    end
  end

  // basic mode transmit buffer handshake with the protocol engine
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_active_reg <= 1'b0;
      core_tx_load  <= 1'b0;
      core_tx_abort <= 1'b0;
    end else begin
      core_tx_load <= load_now;
      if (load_now) begin
        tx_active_reg <= 1'b1;
      end else if (core_tx_done || core_tx_fail) begin
        // a failed frame is retried only while busy still stands
        tx_active_reg <= 1'b0;
      end
      core_tx_abort <= tx_active_reg & ~busy_reg[0];
    end
  end

  // set one words feed the shift register straight from the flops
  assign core_tx_arb    = if_reg[0][1];
  assign core_tx_ctl    = if_reg[0][2];
  assign core_tx_data_a = if_reg[0][3];
  assign core_tx_data_b = if_reg[0][4];

  // ready output held inactive in basic mode, nothing to wait for
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      msg_wait_n <= 1'b1;
    end else begin
      msg_wait_n <= basic | (xf_reg == canmh_pkg::CANMH_XF_IDLE);
    end
  end

  // unmapped offsets read back as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (wb_adr_i == `CANMH_ADR_CTRL) begin
      rd_next[`CANMH_CTRL_INIT] = init_reg;
      rd_next[`CANMH_CTRL_TEST] = test_en_reg;
    end else if (wb_adr_i == `CANMH_ADR_TEST) begin
      rd_next[`CANMH_TEST_BASIC]  = basic_reg;
      rd_next[`CANMH_TEST_SILENT] = silent_reg;
      rd_next[`CANMH_TEST_LOOPBACK_ENABLE]  = loopback_enable_reg;
      rd_next[`CANMH_TEST_SEL_HI:`CANMH_TEST_SEL_LO] = pin_sel_reg;
      rd_next[`CANMH_TEST_RXMON]  = bus_receive_input;
    end else if (if_hit) begin
      if (if_word == `CANMH_IF_CMDREQ) begin
        rd_next[`CANMH_REQ_BUSY] = busy_reg[if_sel];
        rd_next[4:0] = if_num_reg[if_sel];
      end else if (if_word == `CANMH_IF_CMDMASK) begin
        rd_next[7:0] = if_mask_reg[if_sel];
      end else if (if_word < 3'(`CANMH_IF_PART0 + `CANMH_PARTS)) begin
        rd_next = if_reg[if_sel][3'(if_word - `CANMH_IF_PART0)];
        if (basic && if_word == 3'(`CANMH_IF_PART0 + 2)) begin
          rd_next = rd_next & `CANMH_CTL_BASIC_KEEP;
        end
      end
    end
  end

  // ack is a flop, so every access takes exactly one wait state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_next : 32'h0000_0000;
    end
  end

  // objects must be set up before init is left; no hardware

endmodule : canmh_core

// file: sim/canmh_xcvr.sv
`timescale 1ns/1ps
// transceiver plus one remote node; the line idles recessive through the bus termination
module canmh_xcvr (
  input  wire logic tx_pin,
  input  wire logic remote_dom,
  output logic      rx_pin
);
  // wired-and: any dominant driver wins, released line reads recessive
  assign rx_pin = tx_pin & ~remote_dom;
endmodule : canmh_xcvr

// file: sim/canmh_core_chk.sv
`timescale 1ns/1ps
module canmh_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        bus_transmit_output,
  input wire logic        core_tx_bit,
  input wire logic        core_rx_bit,
  input wire logic        core_ack_err_ignore,
  input wire logic        core_tx_enable,
  input wire logic        core_bus_idle,
  input wire logic        core_tx_load,
  input wire logic        msg_wait_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_take |=> s_pulse;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not a one cycle pulse");
  property p_dat;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat: assert property (p_dat)
    else $error("read data not zero outside answer");
  property p_quiet;
    !core_tx_enable |-> bus_transmit_output;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("pin dominant while transmit disabled");
  property p_loop_rx;
    core_ack_err_ignore && $past(core_ack_err_ignore) |-> core_rx_bit == $past(core_tx_bit);
  endproperty
  a_loop_rx: assert property (p_loop_rx)
    else $error("loop back receive bit not own transmit bit");
  property p_load_pulse;
    core_tx_load |=> !core_tx_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("load longer than one cycle");
  property p_load_idle;
    core_tx_load |-> $past(core_bus_idle);
  endproperty
  a_load_idle: assert property (p_load_idle)
    else $error("load without idle bus");
  property p_load_en;
    core_tx_load |-> core_tx_enable;
  endproperty
  a_load_en: assert property (p_load_en)
    else $error("load while transmit disabled");
  property p_wait_bound;
    $fell(msg_wait_n) |-> ##[1:4] msg_wait_n;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("memory transfer too long");
endmodule : canmh_chk

bind canmh_core canmh_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .bus_transmit_output(bus_transmit_output),
  .core_tx_bit(core_tx_bit), .core_rx_bit(core_rx_bit),
  .core_ack_err_ignore(core_ack_err_ignore), .core_tx_enable(core_tx_enable),
  .core_bus_idle(core_bus_idle), .core_tx_load(core_tx_load), .msg_wait_n(msg_wait_n)
);

// file: sim/canmh_core_test.sv
`timescale 1ns/1ps
module canmh_core_test;
  logic        clk_sys = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o, t_arb, t_ctl, t_da, t_db;
  logic        tx_bit = 1, sp = 1, idle = 0, done = 0, fail = 0, rxv = 0, remote = 0;
  logic [31:0] s_arb = 32'h0, s_da = 32'h0, s_db = 32'h0;
  logic [3:0]  s_dlc = 4'h0;
  logic        ack, txo, rx_pin, rx_bit, ack_ign, tx_en, load, abort_o, wait_n;
  logic        wait_seen = 0;
  int          n_mismatch = 0, n_tests = 0, n_load = 0;
  canmh_core DUT (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .bus_receive_input(rx_pin), .bus_transmit_output(txo),
    .core_tx_bit(tx_bit), .core_sample_point(sp), .core_rx_bit(rx_bit),
    .core_ack_err_ignore(ack_ign), .core_tx_enable(tx_en), .core_bus_idle(idle),
    .core_tx_load(load), .core_tx_abort(abort_o), .core_tx_arb(t_arb), .core_tx_ctl(t_ctl),
    .core_tx_data_a(t_da), .core_tx_data_b(t_db), .core_tx_done(done),
    .core_tx_fail(fail), .core_rx_valid(rxv), .core_shift_arb(s_arb),
    .core_shift_dlc(s_dlc), .core_shift_data_a(s_da), .core_shift_data_b(s_db),
    .msg_wait_n(wait_n));
  canmh_xcvr u_xcvr (.tx_pin(txo), .remote_dom(remote), .rx_pin(rx_pin));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (load === 1'b1) n_load++;
    if (nrst && wait_n === 1'b0) wait_seen = 1;
  end
  task end_of_test;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // held until ack is seen at an edge, data taken at that same edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && i < 50);
    rdat = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    if (i >= 50) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task wait_free(input logic [7:0] a);
    int i;
    i = 0;
    do begin
      rd(a);
      i++;
    end while (rdat[15] !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : wait_free
  task wait_load(input int k);
    int i;
    for (i = 0; i < 40 && n_load <= k; i++) tick(1);
    chk("load count", n_load, k + 1);
  endtask : wait_load
  task t_regs;
    rd(8'h00); chk("ctrl reset", rdat, 32'h01);
    rd(8'h04); chk("test reset", rdat, 32'h80);
    wr(8'h04, 32'h1c); rd(8'h04); chk("test locked", rdat, 32'h80);
    rd(8'hfc); chk("unmapped", rdat, 32'h0);
    wr(8'h00, 32'h80); wr(8'h04, 32'h1c); rd(8'h04); chk("test open", rdat, 32'h9c);
  endtask : t_regs
  task t_pin;
    int k;
    for (k = 0; k < 4; k++) begin
      wr(8'h04, 32'(k) << 5);
      tick(2);
      chk("pin select", txo, (k != 2));
    end
    wr(8'h04, 32'h40); tick(4); rd(8'h04); chk("rx monitor", rdat, 32'h40);
    wr(8'h00, 32'h00); tick(2); chk("test off", txo, 1);
  endtask : t_pin
  task t_modes;
    wr(8'h00, 32'h80); tx_bit <= 0;
    // pin select written back to data with every mode change
    wr(8'h04, 32'h08); tick(2);
    chk("silent pin", txo, 1); chk("silent tx_en", tx_en, 0);
    chk("silent rx", rx_bit, 0);
    remote <= 1; tx_bit <= 1; wr(8'h04, 32'h10); tick(2);
    chk("loop rx", rx_bit, 1);
    chk("ack ignore", ack_ign, 1);
    tx_bit <= 0; tick(2); chk("loop pin", txo, 0);
    remote <= 0; wr(8'h04, 32'h18); tick(2);
    chk("hot pin", txo, 1); chk("hot rx", rx_bit, 0);
  endtask : t_modes
  task t_basic_tx;
    int k;
    wr(8'h04, 32'h04); tx_bit <= 1;
    wr(8'h2c, 32'h8000_1234); wr(8'h20, 32'h8000); wr(8'h2c, 32'h0); tick(1);
    chk("locked arb", t_arb, 32'h8000_1234);
    k = n_load; idle <= 1; wait_load(k);
    done <= 1; tick(1); done <= 0; tick(2);
    rd(8'h20); chk("busy done", {31'h0, rdat[15]}, 0);
    k = n_load; wr(8'h20, 32'h8000); wait_load(k);
    k = n_load; wr(8'h20, 32'h0); tick(1); chk("abort", abort_o, 1);
    fail <= 1; tick(1); fail <= 0; tick(8);
    chk("no retry", n_load, k);
    idle <= 0;
  endtask : t_basic_tx
  task t_basic_rx;
    s_arb <= 32'h1111_2222; s_dlc <= 4'h5; s_da <= 32'h0000_a5a5;
    rxv <= 1; tick(1); rxv <= 0;
    rd(8'h4c); chk("rx arb", rdat, 32'h1111_2222);
    rd(8'h50); chk("rx ctrl", rdat, 32'h8005);
    rxv <= 1; tick(1); rxv <= 0;
    rd(8'h50); chk("rx lost", rdat, 32'hc005);
    s_da <= 32'h3c3c; wr(8'h40, 32'h8000); tick(2);
    rd(8'h54); chk("snapshot", rdat, 32'h3c3c);
    chk("no handler wait", wait_seen, 0);
  endtask : t_basic_rx
  task t_xfer;
    // objects set up while init stands, init never left here
    wr(8'h04, 32'h0); wr(8'h00, 32'h01);
    wr(8'h28, 32'hff); wr(8'h2c, 32'h8000_0abc); wr(8'h34, 32'h1111_1111);
    wr(8'h24, 32'h9f); wr(8'h20, 32'h03); wait_free(8'h20);
    chk("wait seen", wait_seen, 1);
    wr(8'h2c, 32'hdead); wr(8'h34, 32'h3333_3333);
    wr(8'h24, 32'h88); wr(8'h20, 32'h03); wait_free(8'h20);
    rd(8'h2c); chk("rmw refresh", rdat, 32'h8000_0abc);
    wr(8'h4c, 32'h5a); wr(8'h44, 32'h08); wr(8'h40, 32'h03); wait_free(8'h40);
    rd(8'h54); chk("read part", rdat, 32'h3333_3333);
    rd(8'h4c); chk("read keep", rdat, 32'h5a);
    nrst <= 0; tick(4); nrst <= 1;
    wr(8'h44, 32'h1f); wr(8'h40, 32'h03); wait_free(8'h40);
    rd(8'h4c); chk("reset valid", rdat, 32'h0000_0abc);
    rd(8'h54); chk("reset data", rdat, 32'h3333_3333);
  endtask : t_xfer
  initial begin
    tick(4);
    nrst <= 1;
    t_regs;
    t_pin;
    t_modes;
    t_basic_tx;
    t_basic_rx;
    t_xfer;
    end_of_test;
  end
endmodule : canmh_core_test
